/* inc/scp_pkg.sv */
// Constants, field layouts and shared types of the serial command port.
// Assumes one 50 MHz system clock and a 32-bit AHB-Lite register bus.
package scp_pkg;
   // ------------------------------------------------------------
   // Clock and rates
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned OVERSAMPLE = 16;
   localparam int unsigned BAUD_300 = 300;
   localparam int unsigned BAUD_600 = 600;
   localparam int unsigned BAUD_1200 = 1200;
   localparam int unsigned BAUD_2400 = 2400;
   localparam int unsigned BAUD_4800 = 4800;
   localparam int unsigned BAUD_9600 = 9600;
   localparam int unsigned BAUD_19200 = 19200;

   // ------------------------------------------------------------
   // Register word indices, decoded from haddr[7:2]
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_CONFIG = 6'h00;
   localparam logic [5:0] IDX_EVENTS = 6'h01;
   localparam logic [5:0] IDX_RXDATA = 6'h02;
   localparam logic [5:0] IDX_TXDATA = 6'h03;
   localparam logic [5:0] IDX_FORMAT = 6'h04;
   localparam logic [5:0] IDX_STATUS = 6'h05;

   // ------------------------------------------------------------
   // Config fields, reset value 9600 baud 8N1 send-receive
   // ------------------------------------------------------------
   localparam int CFG_BAUD_LSB = 0;
   localparam int CFG_BITS8 = 3;
   localparam int CFG_PAR_LSB = 4;
   localparam int CFG_STOP2 = 6;
   localparam int CFG_TALK_ONLY = 7;
   localparam logic [7:0] CFG_RESET = 8'h0d;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ODD = 2'h1;

   // ------------------------------------------------------------
   // Event bits; rx module drives bits 0 to 4
   // ------------------------------------------------------------
   localparam int EV_FRAMING = 0;
   localparam int EV_PARITY = 1;
   localparam int EV_OVERRUN = 2;
   localparam int EV_BREAK = 3;
   localparam int EV_NOISE = 4;
   localparam int EV_SETTINGS_LOST = 6;
   localparam int EV_INPUT_OVERFLOW = 7;
   localparam int EV_FORMAT = 8;
   localparam int EV_SUMMARY = 11;

   // ------------------------------------------------------------
   // Characters and input queue
   // ------------------------------------------------------------
   localparam logic [7:0] CH_CTRL_C = 8'h03;
   localparam logic [7:0] CH_CTRL_X = 8'h18;
   localparam logic [7:0] CH_XON = 8'h11;
   localparam logic [7:0] CH_XOFF = 8'h13;
   localparam logic [7:0] CH_LF = 8'h0a;
   localparam logic [7:0] CH_CR = 8'h0d;
   localparam logic [7:0] ACK_CH0 = 8'h44;
   localparam logic [7:0] ACK_CH1 = 8'h43;
   localparam logic [7:0] ACK_CH2 = 8'h4c;
   localparam int QUEUE_DEPTH = 2048;
   localparam logic [11:0] QUEUE_FULL = 12'(QUEUE_DEPTH);
   localparam logic [11:0] QUEUE_HI = 12'(QUEUE_DEPTH * 3 / 4);
   localparam logic [11:0] QUEUE_LO = 12'(QUEUE_DEPTH / 2);

   typedef enum logic [1:0] {SCP_RX_IDLE, SCP_RX_START, SCP_RX_BITS} scp_rx_state_e;

   // Oversample divider reload for the selected rate
   function automatic logic [13:0] scp_baud_div(input logic [2:0] sel);
      case (sel)
         3'h0: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_300) - 1);
         3'h1: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_600) - 1);
         3'h2: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_1200) - 1);
         3'h3: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_2400) - 1);
         3'h4: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_4800) - 1);
         3'h6: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_19200) - 1);
         default: scp_baud_div = 14'(CLK_HZ / (OVERSAMPLE * BAUD_9600) - 1);
      endcase
   endfunction

   // Bits after the start bit: data, parity, stop
   function automatic logic [3:0] scp_frame_bits(input logic [7:0] cfg);
      scp_frame_bits = 4'h8 + {3'h0, cfg[CFG_BITS8]} + {3'h0, cfg[CFG_STOP2]}
         + {3'h0, cfg[CFG_PAR_LSB +: 2] != PAR_NONE};
   endfunction
endpackage

/* sim/scp_host.sv */
// Host terminal model: sends and receives 8N1 characters on the serial pair.
// Assumes the port runs at the rate implied by BIT_CYC clock cycles per bit.
`timescale 1ns/1ps
module scp_host #(
   parameter int BIT_CYC = 2592
) (
   input wire logic hclk,
   output logic rxd,
   input wire logic txd
);
   // ----------------------------------------
   // Line drivers
   // ----------------------------------------
   // Idle at mark level; no handshake lines exist at all
   initial rxd = 1'b1;
   // Start bit, eight data bits LSB first, one stop bit
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge hclk);
         rxd <= f[i];
         repeat (BIT_CYC - 1) @(posedge hclk);
      end
   endtask
   // Samples mid-bit; the bench timeout cuts a silent line short
   task automatic recv(output logic [7:0] c);
      while (txd !== 1'b0) @(posedge hclk);
      repeat (BIT_CYC / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge hclk);
         c[i] = txd;
      end
   endtask
endmodule

/* sim/scp_top_chk.sv */
// Checker of the serial command port, watching the top module's ports.
// Assumes the zero-wait register bus of the port and one clock.
`timescale 1ns/1ps
module scp_top_chk
   import scp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic device_clear,
   input wire logic line_ready,
   input wire logic serial_error_summary_bit
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire take_r = hsel & hready & htrans[1] & !hwrite;
   wire take_w = hsel & hready & htrans[1] & hwrite;
   bus_okay_a: assert property (hresp == 1'b0) else $error("error response seen");
   bus_ready_a: assert property (hreadyout) else $error("wait state inserted");
   clear_pulse_a: assert property (
      device_clear |=> !device_clear) else $error("clear pulse too long");
   summary_sticky_a: assert property (
      serial_error_summary_bit && !take_w && !$past(take_w) && !$past(take_w, 2)
      |=> serial_error_summary_bit) else $error("summary dropped unasked");
   rdata_hold_a: assert property (!take_r |=> $stable(hrdata)) else $error("read data moved");
   unmapped_zero_a: assert property (
      take_r && haddr[7:2] > IDX_STATUS |=> hrdata == 32'h0) else $error("unmapped not zero");
   format_ascii_a: assert property (
      take_r && haddr[7:2] == IDX_FORMAT |=> hrdata == 32'h0) else $error("format not ascii");
   rx_width_a: assert property (
      take_r && haddr[7:2] == IDX_RXDATA |=> hrdata[31:9] == 23'h0) else $error("rx high bits");
   cover property (device_clear);
   cover property ($rose(line_ready));
   cover property ($rose(serial_error_summary_bit));
endmodule
bind scp_top scp_top_chk chk_u (.*);

/* sim/serial_command_port_test.sv */
// Testbench of the serial command port: register tasks and host traffic.
// Assumes the host model at 19200 baud, 8N1, matching stored_cfg.
`timescale 1ns/1ps
module serial_command_port_test
   import scp_pkg::*;
;
   localparam int BIT_CYC = 16 * (CLK_HZ / (OVERSAMPLE * BAUD_19200));
   logic hclk, hresetn, settings_lost, hwrite, hreadyout, hresp, rxd, txd;
   logic device_clear, line_ready, sum_bit;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [7:0] stored_cfg, ch;
   int error_cnt = 0, checked = 0, dcl_cnt = 0, cyc = 0;
   scp_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
      .settings_lost(settings_lost), .stored_cfg(stored_cfg), .device_clear(device_clear),
      .line_ready(line_ready), .serial_error_summary_bit(sum_bit));
   scp_host #(.BIT_CYC(BIT_CYC)) host_u (.hclk(hclk), .rxd(rxd), .txd(txd));
   // ----------------------------------------
   // Clock, watchdog and tasks
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // Two sent frames and one overlapped receive need about 75k cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (device_clear === 1'b1) dcl_cnt <= dcl_cnt + 1;
      if (cyc == 95000) begin
         error_cnt++;
         end_sim();
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] r);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task rst(input logic lost);
      hresetn <= 1'b0;
      settings_lost <= lost;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      hresetn = 1'b0;
      settings_lost = 1'b0;
      stored_cfg = 8'h0e;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      rst(1'b0);
      bus(32'h00, 1'b0, 32'h0, rd);
      chk("config", 32'h0e, rd);
      bus(32'h10, 1'b1, 32'h1, rd);
      bus(32'h04, 1'b0, 32'h0, rd);
      chk("events", 32'h900, rd);
      chk("summary", 32'h1, {31'h0, sum_bit});
      bus(32'h10, 1'b0, 32'h0, rd);
      chk("format", 32'h0, rd);
      bus(32'h04, 1'b1, 32'h900, rd);
      bus(32'h04, 1'b0, 32'h0, rd);
      chk("events cleared", 32'h0, rd);
      bus(32'h40, 1'b0, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      host_u.send(CH_LF);
      repeat (40) @(posedge hclk);
      chk("line ready", 32'h1, {31'h0, line_ready});
      bus(32'h08, 1'b0, 32'h0, rd);
      chk("rx line feed", {23'h0, 1'b1, CH_LF}, rd);
      bus(32'h08, 1'b0, 32'h0, rd);
      chk("rx empty", 32'h0, rd);
      // Receiver armed before the clear, so the first start bit is caught
      fork
         host_u.send(CH_CTRL_C);
         host_u.recv(ch);
      join
      repeat (40) @(posedge hclk);
      chk("clear pulses", 32'h1, 32'(dcl_cnt));
      chk("ack first char", {24'h0, ACK_CH0}, {24'h0, ch});
      // Second reset mid-transmission, stored settings lost
      rst(1'b1);
      bus(32'h00, 1'b0, 32'h0, rd);
      chk("default config", {24'h0, CFG_RESET}, rd);
      bus(32'h04, 1'b0, 32'h0, rd);
      chk("lost event", 32'h840, rd);
      end_sim();
   end
endmodule

/* src/scp_rx.sv */
// Receiver: 16x oversampled, majority vote, error and break detection.
// Assumes rxd synchronous to hclk and tick a one-cycle 16x rate enable.
`timescale 1ns/1ps
module scp_rx
   import scp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic rxd,
   input wire logic [7:0] cfg,
   input wire logic ack,
   output logic [7:0] data,
   output logic valid,
   output logic [4:0] evt
);
   typedef struct packed {
      scp_rx_state_e st;
      logic [3:0] sub;
      logic [3:0] idx;
      logic [10:0] sh;
      logic [1:0] ones;
      logic noisy;
      logic [7:0] low_cnt;
      logic brk;
      logic [7:0] data;
      logic valid;
      logic [4:0] evt;
   } scp_rx_s;

   scp_rx_s r;
   scp_rx_s n;

   always_comb begin
      logic [3:0] nbits;
      logic [1:0] votes;
      logic [10:0] fr;
      logic [7:0] d;
      logic pbit;
      logic bad_par;
      logic bad_stop;
      nbits = scp_frame_bits(cfg);
      votes = r.ones + {1'b0, rxd};
      fr = '0;
      d = '0;
      pbit = 1'b0;
      bad_par = 1'b0;
      bad_stop = 1'b0;
      n = r;
      n.evt = '0;
      if (ack) begin
         n.valid = 1'b0;
      end
      if (tick) begin
         case (r.st)
            SCP_RX_IDLE: begin
               if (!rxd && !r.brk) begin
                  n.st = SCP_RX_START;
                  n.sub = '0;
               end
            end
            SCP_RX_START: begin
               n.sub = r.sub + 4'h1;
               if (r.sub == 4'h7) begin
                  n.sub = '0;
                  n.idx = '0;
                  n.ones = '0;
                  n.noisy = 1'b0;
                  n.st = rxd ? SCP_RX_IDLE : SCP_RX_BITS;
                  n.evt[EV_FRAMING] = rxd;
               end
            end
            SCP_RX_BITS: begin
               n.sub = r.sub + 4'h1;
               if (r.sub >= 4'hd) begin
                  n.ones = votes;
               end
               if (r.sub == 4'hf) begin
                  n.ones = '0;
                  n.noisy = r.noisy | (votes != 2'h0 && votes != 2'h3);
                  n.sh = {votes[1], r.sh[10:1]};
                  n.idx = r.idx + 4'h1;
                  if (r.idx == nbits - 4'h1) begin
                     n.st = SCP_RX_IDLE;
                     fr = n.sh >> (4'hb - nbits);
                     d = cfg[CFG_BITS8] ? fr[7:0] : {1'b0, fr[6:0]};
                     pbit = cfg[CFG_BITS8] ? fr[8] : fr[7];
                     bad_par = (cfg[CFG_PAR_LSB +: 2] != PAR_NONE)
                        && ((^d ^ pbit) != (cfg[CFG_PAR_LSB +: 2] == PAR_ODD));
                     bad_stop = !fr[nbits - 4'h1] || (cfg[CFG_STOP2] && !fr[nbits - 4'h2]);
                     n.evt[EV_FRAMING] = bad_stop;
                     n.evt[EV_PARITY] = bad_par;
                     n.evt[EV_NOISE] = n.noisy;
                     // Old character kept on overrun, the new one is lost
                     if (!bad_stop) begin
                        if (r.valid && !ack) begin
                           n.evt[EV_OVERRUN] = 1'b1;
                        end else begin
                           n.data = d;
                           n.valid = 1'b1;
                        end
                     end
                  end
               end
            end
            default: n.st = SCP_RX_IDLE;
         endcase
         // Line low past a whole frame, stop bits included
         if (rxd) begin
            n.low_cnt = '0;
            n.brk = 1'b0;
         end else if (!r.brk) begin
            if (r.low_cnt == {4'(nbits + 4'h1), 4'h0}) begin
               n.brk = 1'b1;
               n.evt[EV_BREAK] = 1'b1;
               n.st = SCP_RX_IDLE;
            end else begin
               n.low_cnt = r.low_cnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{st: SCP_RX_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign data = r.data;
   assign valid = r.valid;
   assign evt = r.evt;
endmodule

/* src/scp_top.sv */
// Serial command port: AHB-Lite registers, input queue, flow control,
// device-clear and error events around one receiver and one transmitter.
// Assumes all inputs synchronous to hclk and a single AHB-Lite master.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps

// Contract
// - Rate selectable among 300 to 19200 baud; host matches it.
// - Seven or eight data bits, one or two stop bits, both ends alike.
// - Parity none, odd or even, generated on send, checked on receive.
// - Send-receive mode, or talk-only mode that accepts no commands.
// - No handshake lines; flow control only by in-band XON and XOFF.
// - Send XOFF once the 2048-character queue passes three quarters full.
// - After XOFF, send XON once the queue falls below half full.
// - Received XOFF stops our output until XON arrives; our own XON and XOFF still go out during the pause.
// - Received text is released for execution only after a line feed.
// - Control-C forces device-clear: abort work, drop unsent output.
// - Control-X acts as a second device-clear character.
// - Break on the line does device-clear and raises break event.
// - After device-clear send the acknowledge text, then CR and LF.
// - Any serial error event sets the summary bit eleven.
// - Bad start or stop bit raises the framing event.
// - Failed parity check raises the parity event.
// - Character arriving before previous one is read raises overrun.
// - Noise during a character raises the noise event.
// - Settings lost at power-up: 9600 8N1 and settings-lost event.
// - Line feed closes a buffer; no space means discard and overflow event.
// - Output format stays ASCII; other format requests raise an event.
// - Query responses are sent at once, unasked.
module scp_top
   import scp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rxd,
   output logic txd,
   input wire logic settings_lost,
   input wire logic [7:0] stored_cfg,
   output logic device_clear,
   output logic line_ready,
   output logic serial_error_summary_bit
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] cfg;
      logic init_done;
      logic [11:0] events;
      logic [10:0] wr_ptr;
      logic [10:0] rd_ptr;
      logic [11:0] count;
      logic [11:0] commit_cnt;
      logic [11:0] pend_cnt;
      logic xoff_sent;
      logic fc_req;
      logic [7:0] fc_char;
      logic host_paused;
      logic [7:0] hold;
      logic hold_v;
      logic [2:0] ack_idx;
      logic tx_start;
      logic [7:0] tx_data;
      logic rx_ack;
      logic [13:0] div_cnt;
      logic tick;
      logic dph_wr;
      logic [5:0] dph_idx;
      logic [31:0] hrdata;
      logic hreadyout;
      logic clr;
      logic line_ready;
      logic summary;
   } scp_top_s;

   scp_top_s r;
   scp_top_s n;
   logic [7:0] queue_mem [0:QUEUE_DEPTH-1];
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [7:0] rx_data;
   logic rx_valid;
   logic [4:0] rx_evt;
   logic tx_busy;

   // ------------------------------------------------------------
   // Line side
   // ------------------------------------------------------------
   scp_rx u_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(r.tick),
      .rxd(rxd),
      .cfg(r.cfg),
      .ack(r.rx_ack),
      .data(rx_data),
      .valid(rx_valid),
      .evt(rx_evt)
   );

   scp_tx u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(r.tick),
      .cfg(r.cfg),
      .start(r.tx_start),
      .data(r.tx_data),
      .busy(tx_busy),
      .txd(txd)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [11:0] ev_set;
      logic acc;
      logic clear_now;
      logic [7:0] c;
      ev_set = '0;
      acc = hsel && hready && htrans[1];
      clear_now = 1'b0;
      c = rx_data;
      mem_we = 1'b0;
      mem_wdata = '0;
      n = r;
      n.tick = 1'b0;
      n.tx_start = 1'b0;
      n.rx_ack = 1'b0;
      n.clr = 1'b0;
      n.dph_wr = 1'b0;

      // 16x rate enable from the selected divider
      if (r.div_cnt == 14'h0000) begin
         n.div_cnt = scp_baud_div(r.cfg[CFG_BAUD_LSB +: 3]);
         n.tick = 1'b1;
      end else begin
         n.div_cnt = r.div_cnt - 14'h0001;
      end

      // Stored settings taken in the first cycle after reset
      if (!r.init_done) begin
         n.init_done = 1'b1;
         if (settings_lost) begin
            n.cfg = CFG_RESET;
            ev_set[EV_SETTINGS_LOST] = 1'b1;
         end else begin
            n.cfg = stored_cfg;
         end
      end

      ev_set[4:0] = rx_evt;

      // Write data phase
      if (r.dph_wr) begin
         case (r.dph_idx)
            IDX_CONFIG: n.cfg = hwdata[7:0];
            IDX_EVENTS: n.events = r.events & ~hwdata[11:0];
            IDX_TXDATA: begin
               if (!r.hold_v) begin
                  n.hold = hwdata[7:0];
                  n.hold_v = 1'b1;
               end
            end
            IDX_FORMAT: ev_set[EV_FORMAT] = hwdata != 32'h0000_0000;
            default: n.cfg = n.cfg;
         endcase
      end

      // Address phase; read data is registered for the data phase
      if (acc) begin
         n.dph_wr = hwrite;
         n.dph_idx = haddr[7:2];
         if (!hwrite) begin
            case (haddr[7:2])
               IDX_CONFIG: n.hrdata = {24'h000000, r.cfg};
               IDX_EVENTS: n.hrdata = {20'h00000, r.events};
               IDX_RXDATA: begin
                  n.hrdata = '0;
                  if (r.commit_cnt != 12'h000) begin
                     n.hrdata = {23'h000000, 1'b1, queue_mem[r.rd_ptr]};
                     n.rd_ptr = r.rd_ptr + 11'h001;
                     n.count = r.count - 12'h001;
                     n.commit_cnt = r.commit_cnt - 12'h001;
                  end
               end
               IDX_TXDATA: n.hrdata = {31'h00000000, r.hold_v};
               IDX_FORMAT: n.hrdata = '0;
               IDX_STATUS: n.hrdata = {12'h000, r.ack_idx != 3'h0, tx_busy,
                  r.host_paused, r.xoff_sent, 4'h0, r.count};
               default: n.hrdata = '0;
            endcase
         end
      end

      // Received characters
      if (rx_valid && !r.rx_ack) begin
         n.rx_ack = 1'b1;
         if (c == CH_XOFF) begin
            n.host_paused = 1'b1;
         end else if (c == CH_XON) begin
            n.host_paused = 1'b0;
         end else if (c == CH_CTRL_C || c == CH_CTRL_X) begin
            clear_now = 1'b1;
         end else if (r.cfg[CFG_TALK_ONLY]) begin
            n.rx_ack = 1'b1;
         end else if (n.count == QUEUE_FULL) begin
            ev_set[EV_INPUT_OVERFLOW] = 1'b1;
         end else begin
            mem_we = 1'b1;
            mem_wdata = c;
            n.wr_ptr = r.wr_ptr + 11'h001;
            n.count = n.count + 12'h001;
            // Text stays hidden from software until its line feed
            if (c == CH_LF) begin
               n.commit_cnt = n.commit_cnt + r.pend_cnt + 12'h001;
               n.pend_cnt = '0;
            end else begin
               n.pend_cnt = r.pend_cnt + 12'h001;
            end
         end
      end
      if (rx_evt[EV_BREAK]) begin
         clear_now = 1'b1;
      end

      // Device-clear empties queue and pending output
      if (clear_now) begin
         n.clr = 1'b1;
         n.wr_ptr = '0;
         n.rd_ptr = '0;
         n.count = '0;
         n.commit_cnt = '0;
         n.pend_cnt = '0;
         n.hold_v = 1'b0;
         n.ack_idx = 3'h1;
      end

      // In-band flow control on queue level
      if (!r.fc_req) begin
         if (!r.xoff_sent && n.count > QUEUE_HI) begin
            n.fc_req = 1'b1;
            n.fc_char = CH_XOFF;
            n.xoff_sent = 1'b1;
         end else if (r.xoff_sent && n.count < QUEUE_LO) begin
            n.fc_req = 1'b1;
            n.fc_char = CH_XON;
            n.xoff_sent = 1'b0;
         end
      end

      // Flow control chars bypass a host pause so the host never deadlocks
      if (!tx_busy && !r.tx_start) begin
         if (r.fc_req) begin
            n.fc_req = 1'b0;
            n.tx_start = 1'b1;
            n.tx_data = r.fc_char;
         end else if (!r.host_paused) begin
            if (r.ack_idx != 3'h0) begin
               n.tx_start = 1'b1;
               n.ack_idx = (r.ack_idx == 3'h5) ? 3'h0 : r.ack_idx + 3'h1;
               case (r.ack_idx)
                  3'h1: n.tx_data = ACK_CH0;
                  3'h2: n.tx_data = ACK_CH1;
                  3'h3: n.tx_data = ACK_CH2;
                  3'h4: n.tx_data = CH_CR;
                  default: n.tx_data = CH_LF;
               endcase
            end else if (n.hold_v) begin
               n.tx_start = 1'b1;
               n.tx_data = n.hold;
               n.hold_v = 1'b0;
            end
         end
      end

      // Set wins over a same-cycle write-one clear
      n.events = n.events | ev_set;
      if (ev_set != 12'h000) begin
         n.events[EV_SUMMARY] = 1'b1;
      end
      n.summary = n.events[EV_SUMMARY];
      n.line_ready = n.commit_cnt != 12'h000;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{cfg: CFG_RESET, hreadyout: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   // Queue storage has no reset; pointers decide what is valid
   always_ff @(posedge hclk) begin
      if (mem_we) begin
         queue_mem[r.wr_ptr] <= mem_wdata;
      end
   end

   assign hrdata = r.hrdata;
   assign hreadyout = r.hreadyout;
   assign hresp = 1'b0;
   assign device_clear = r.clr;
   assign line_ready = r.line_ready;
   assign serial_error_summary_bit = r.summary;
endmodule

/* src/scp_tx.sv */
// Transmitter: builds one character frame and shifts it out on txd.
// Assumes tick is a one-cycle 16x rate enable; start ignored while busy.
`timescale 1ns/1ps
module scp_tx
   import scp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic [7:0] cfg,
   input wire logic start,
   input wire logic [7:0] data,
   output logic busy,
   output logic txd
);
   typedef struct packed {
      logic busy;
      logic [3:0] sub;
      logic [3:0] left;
      logic [11:0] f;
      logic txd;
   } scp_tx_s;

   scp_tx_s r;
   scp_tx_s n;

   always_comb begin
      logic [7:0] d;
      logic pb;
      logic [8:0] pl;
      logic has_par;
      pl = '0;
      d = cfg[CFG_BITS8] ? data : {1'b0, data[6:0]};
      pb = (^d) ^ (cfg[CFG_PAR_LSB +: 2] == PAR_ODD);
      has_par = cfg[CFG_PAR_LSB +: 2] != PAR_NONE;
      // Unused high bits are ones, so they double as stop bits
      if (cfg[CFG_BITS8]) begin
         pl = has_par ? {pb, d} : {1'b1, d};
      end else begin
         pl = has_par ? {1'b1, pb, d[6:0]} : {2'h3, d[6:0]};
      end
      n = r;
      if (start && !r.busy) begin
         n.busy = 1'b1;
         n.f = {2'h3, pl, 1'b0};
         n.left = scp_frame_bits(cfg) + 4'h1;
         n.sub = '0;
      end else if (r.busy && tick) begin
         n.sub = r.sub + 4'h1;
         if (r.sub == 4'hf) begin
            n.f = {1'b1, r.f[11:1]};
            n.left = r.left - 4'h1;
            n.busy = r.left != 4'h1;
         end
      end
      n.txd = n.busy ? n.f[0] : 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '{f: '1, txd: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign busy = r.busy;
   assign txd = r.txd;
endmodule
